// >>> core/cpu_bus_exchange_adapter.sv
`timescale 1ns/1ns
// Overview of operation
// - Controller request raises cpu request immediately
// - After grant, acknowledge once address strobe is high
// - Controller granted input is inverted acknowledge
// - Hold cpu request two 100 ns clocks past acknowledge (20 ns rounded up to one whole clock, plus the register stage)
// - Request drop ends acknowledge, cpu regains bus
// - Slave strobes from read/write and byte strobes
// - High byte enable low during slave accesses
// - Address A1-A3 straight through, A0 low
// - Chip select decoded from cpu address
// - Latch lower 16 and upper 8 address
// - Untimed memory: strobe follows latch strobe
// - Timed memory: no strobe before latch, upper
// - Controller ready stretches slave cycles to cpu
// - Controller waits while system ready low
// - Latch strobes never floated, each loads its own address half
// - Strobes out as master, in as slave
// - Reset interrupt, never on non-maskable input
module cpu_bus_exchange_adapter #(
    parameter logic [cpu_bus_exchange_pkg::BASE_W-1:0] HDC_BASE =
        cpu_bus_exchange_pkg::HDC_BASE_DEFAULT,
    parameter bit AS_TIMED = 1'b1
) (
    input wire logic core_clk_i, // System clock
    input wire logic rst_n_i, // Synchronous reset, active low
    cpu_bus_exchange_if.adapter bus, // Link to the controller
    input wire logic [cpu_bus_exchange_pkg::ADDR_W-1:1] cpu_addr_i, // Cpu address
    input wire logic address_strobe_n_i, // Cpu address strobe
    input wire logic read_not_write_i, // Cpu direction, 1 = read
    input wire logic lower_byte_strobe_n_i, // Cpu low byte strobe
    input wire logic upper_byte_strobe_n_i, // Cpu high byte strobe
    input wire logic [cpu_bus_exchange_pkg::DATA_W-1:0] cpu_data_i, // Cpu write data
    output logic [cpu_bus_exchange_pkg::DATA_W-1:0] cpu_data_o, // Slave read data
    output logic cpu_ready_n_o, // Cycle end to cpu, low = done
    input wire logic cpu_grant_n_i, // Cpu bus grant
    output logic cpu_bus_request_n_o, // Bus request to cpu
    output logic grant_acknowledge_n_o, // Bus grant acknowledge
    output logic [cpu_bus_exchange_pkg::ADDR_W-1:0] mem_addr_o, // Latched address
    output logic mem_as_n_o, // Master address strobe
    output logic mem_rnw_o, // Master direction, 1 = read
    output logic mem_data_strobe_n_o, // Master data strobe
    output logic mem_ctl_oe_n_o, // Enable of master strobes
    output logic [cpu_bus_exchange_pkg::DATA_W-1:0] mem_data_o, // Master write data
    output logic mem_data_oe_n_o, // Enable of master write data
    input wire logic [cpu_bus_exchange_pkg::DATA_W-1:0] mem_data_i, // Master read data
    input wire logic mem_ready_i, // System ready, high = done
    output logic irq_o // Controller interrupt, to a maskable input
);
    import cpu_bus_exchange_pkg::*;

    arb_state_t state_r, state_nxt;
    logic as_n_d_r, as_rise, hold_busy, ack_start;
    logic master, cs_hit, slave_rd, slave_wr;
    logic first_ale_r, hdc_strobe, slave_seen_r;

    assign master = !grant_acknowledge_n_o;
    assign as_rise = !as_n_d_r && address_strobe_n_i;
    assign ack_start = (state_r == ARB_WAIT_AS) && (state_nxt == ARB_OWN);

    // Arbitration: request, await grant, await cycle end, own bus
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ARB_IDLE: if (bus.hdc_bus_request) state_nxt = ARB_REQ;
            ARB_REQ: if (!cpu_grant_n_i) state_nxt = ARB_WAIT_AS;
            ARB_WAIT_AS: if (as_rise || (as_n_d_r && address_strobe_n_i)) begin
                state_nxt = ARB_OWN;
            end
            ARB_OWN: if (!bus.hdc_bus_request) state_nxt = ARB_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_r <= ARB_IDLE;
            as_n_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            as_n_d_r <= address_strobe_n_i;
        end
    end

    cycle_hold_timer #(.CNT_W(CNT_W)) u_br_hold (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(ack_start),
        .cycles_i(CNT_W'(BR_HOLD_CYC)),
        .busy_o(hold_busy)
    );

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cpu_bus_request_n_o <= 1'b1;
        end else if (state_r == ARB_IDLE) begin
            cpu_bus_request_n_o <= !bus.hdc_bus_request;
        end else if (state_r == ARB_OWN) begin
            cpu_bus_request_n_o <= !(hold_busy || ack_start);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            grant_acknowledge_n_o <= 1'b1;
            bus.hdc_bus_granted_n <= 1'b1;
        end else begin
            grant_acknowledge_n_o <= (state_nxt != ARB_OWN);
            bus.hdc_bus_granted_n <= (state_nxt != ARB_OWN);
        end
    end

    assign cs_hit = !address_strobe_n_i && (cpu_addr_i[ADDR_W-1:4] == HDC_BASE);
    assign slave_rd = cs_hit && read_not_write_i
                      && (!lower_byte_strobe_n_i || !upper_byte_strobe_n_i);
    assign slave_wr = cs_hit && !read_not_write_i
                      && (!lower_byte_strobe_n_i || !upper_byte_strobe_n_i);

    // drive controller strobes only in slave
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.adp_rd_n_out <= 1'b1;
            bus.adp_wr_n_out <= 1'b1;
            bus.adp_rd_oe_n <= 1'b1;
            bus.adp_wr_oe_n <= 1'b1;
            bus.chip_select_n <= 1'b1;
        end else begin
            bus.adp_rd_n_out <= !(slave_rd && !master);
            bus.adp_wr_n_out <= !(slave_wr && !master);
            bus.adp_rd_oe_n <= master;
            bus.adp_wr_oe_n <= master;
            bus.chip_select_n <= !(cs_hit && !master);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.reg_sel <= '0;
            bus.addr0 <= 1'b0;
            bus.high_byte_enable_n <= 1'b0;
        end else begin
            bus.reg_sel <= cpu_addr_i[SEL_W:1];
            bus.addr0 <= 1'b0;
            bus.high_byte_enable_n <= 1'b0;
        end
    end

    // Data path on the multiplexed bus, by mode and direction
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.adp_ad_out <= '0;
            bus.adp_ad_oe_n <= 1'b1;
            cpu_data_o <= '0;
        end else if (master) begin
            bus.adp_ad_out <= mem_data_i;
            bus.adp_ad_oe_n <= bus.rd_n_line;
        end else begin
            bus.adp_ad_out <= cpu_data_i;
            bus.adp_ad_oe_n <= !slave_wr;
            if (!bus.rd_n_line) begin
                cpu_data_o <= bus.ad_line;
            end
        end
    end

    // controller ready to cpu
    // Pulled-up ready means nothing until the controller has taken the access
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cpu_ready_n_o <= 1'b1;
            slave_seen_r <= 1'b0;
        end else begin
            cpu_ready_n_o <= !(cs_hit && !master && bus.ready_line && slave_seen_r);
            slave_seen_r <= !bus.chip_select_n && (!bus.rd_n_line || !bus.wr_n_line);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.adp_ready_out <= 1'b1;
            bus.adp_ready_oe_n <= 1'b1;
        end else begin
            bus.adp_ready_out <= mem_ready_i;
            bus.adp_ready_oe_n <= !master;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mem_addr_o <= '0;
        end else begin
            if (bus.hdc_ale) begin
                mem_addr_o[ADDR_LO_W-1:0] <= bus.ad_line;
            end else if (!master && !address_strobe_n_i) begin
                mem_addr_o[ADDR_LO_W-1:0] <= {cpu_addr_i[ADDR_LO_W-1:1], 1'b0};
            end
            if (bus.hdc_upper_strobe) begin
                mem_addr_o[ADDR_W-1:ADDR_LO_W] <= bus.ad_line[ADDR_HI_W-1:0];
            end
        end
    end

    // First latch pulse of a bus tenure, for timed memories
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !master) begin
            first_ale_r <= 1'b0;
        end else if (bus.hdc_ale) begin
            first_ale_r <= 1'b1;
        end
    end

    assign hdc_strobe = !bus.rd_n_line || !bus.wr_n_line;

    // Address strobe in master mode, by memory style
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mem_as_n_o <= 1'b1;
        end else if (!AS_TIMED) begin
            mem_as_n_o <= !(master && bus.hdc_ale);
        end else begin
            mem_as_n_o <= !(master && first_ale_r && !bus.hdc_upper_strobe && hdc_strobe);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mem_ctl_oe_n_o <= 1'b1;
            mem_rnw_o <= 1'b1;
            mem_data_strobe_n_o <= 1'b1;
            mem_data_o <= '0;
            mem_data_oe_n_o <= 1'b1;
        end else begin
            mem_ctl_oe_n_o <= !master;
            mem_rnw_o <= bus.wr_n_line;
            mem_data_strobe_n_o <= !(master && hdc_strobe);
            mem_data_o <= bus.ad_line;
            mem_data_oe_n_o <= !(master && !bus.wr_n_line);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= bus.hdc_irq;
        end
    end
endmodule // cpu_bus_exchange_adapter

// >>> core/cycle_hold_timer.sv
`timescale 1ns/1ns
module cycle_hold_timer #(
    parameter int CNT_W = 4
) (
    input wire logic core_clk_i, // System clock
    input wire logic rst_n_i, // Synchronous reset, active low
    input wire logic load_i, // Start a hold period
    input wire logic [CNT_W-1:0] cycles_i, // Length of the hold period
    output logic busy_o // High while the period runs
);
    logic [CNT_W-1:0] count_r;

    // Down counter; a reload restarts the period
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            count_r <= '0;
        end else if (load_i) begin
            count_r <= cycles_i;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign busy_o = (count_r != '0);
endmodule // cycle_hold_timer

// >>> core/hdc_bus_end.sv
`timescale 1ns/1ns
module hdc_bus_end #(
    parameter int SLAVE_WAIT = cpu_bus_exchange_pkg::SLAVE_WAIT_CYC
) (
    input wire logic core_clk_i, // System clock
    input wire logic rst_n_i, // Synchronous reset, active low
    cpu_bus_exchange_if.hdc bus, // Link to the adapter
    input wire logic xfer_req_i, // Pulse: start one master word transfer
    input wire logic xfer_write_i, // Transfer direction, 1 = write
    input wire logic [cpu_bus_exchange_pkg::ADDR_W-1:0] xfer_addr_i, // Memory address
    input wire logic [cpu_bus_exchange_pkg::DATA_W-1:0] xfer_wdata_i, // Write data
    output logic xfer_busy_o, // Master transfer in progress
    output logic xfer_done_o, // Pulse: transfer finished, bus released
    output logic [cpu_bus_exchange_pkg::DATA_W-1:0] xfer_rdata_o, // Read data
    output logic reg_rd_o, // Pulse: slave register read begins
    output logic reg_wr_o, // Pulse: slave register write
    output logic [cpu_bus_exchange_pkg::SEL_W-1:0] reg_sel_o, // Register index
    output logic [cpu_bus_exchange_pkg::DATA_W-1:0] reg_wdata_o, // Slave write data
    input wire logic [cpu_bus_exchange_pkg::DATA_W-1:0] reg_rdata_i, // Slave read data
    input wire logic irq_set_i, // Pulse: raise interrupt
    input wire logic irq_clr_i // Pulse: clear interrupt
);
    import cpu_bus_exchange_pkg::*;

    hdc_master_t state_r, state_nxt;
    logic write_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic slave_acc, slave_acc_d_r, slave_start, wait_busy;

    // Master sequence: request, upper address, lower address, strobe, release
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            HM_IDLE: if (xfer_req_i) state_nxt = HM_REQ;
            HM_REQ: if (!bus.hdc_bus_granted_n) state_nxt = HM_UPPER;
            HM_UPPER: state_nxt = HM_LOWER;
            HM_LOWER: state_nxt = HM_STROBE;
            HM_STROBE: if (bus.ready_line) state_nxt = HM_RELEASE;
            HM_RELEASE: if (bus.hdc_bus_granted_n) state_nxt = HM_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_r <= HM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Transfer parameters held for the whole sequence
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            write_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end else if (state_r == HM_IDLE && xfer_req_i) begin
            write_r <= xfer_write_i;
            addr_r <= xfer_addr_i;
            wdata_r <= xfer_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.hdc_bus_request <= 1'b0;
            xfer_busy_o <= 1'b0;
            xfer_done_o <= 1'b0;
        end else begin
            bus.hdc_bus_request <= (state_nxt inside {HM_REQ, HM_UPPER, HM_LOWER,
                                                      HM_STROBE});
            xfer_busy_o <= (state_nxt != HM_IDLE);
            xfer_done_o <= (state_r == HM_RELEASE) && bus.hdc_bus_granted_n;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.hdc_ale <= 1'b0;
            bus.hdc_upper_strobe <= 1'b0;
        end else begin
            bus.hdc_ale <= (state_nxt == HM_LOWER);
            bus.hdc_upper_strobe <= (state_nxt == HM_UPPER);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.hdc_rd_n_out <= 1'b1;
            bus.hdc_wr_n_out <= 1'b1;
            bus.hdc_rd_oe_n <= 1'b1;
            bus.hdc_wr_oe_n <= 1'b1;
        end else begin
            bus.hdc_rd_n_out <= !(state_nxt == HM_STROBE && !write_r);
            bus.hdc_wr_n_out <= !(state_nxt == HM_STROBE && write_r);
            bus.hdc_rd_oe_n <= (state_nxt inside {HM_IDLE, HM_REQ});
            bus.hdc_wr_oe_n <= (state_nxt inside {HM_IDLE, HM_REQ});
        end
    end

    // Multiplexed bus: addresses, write data, or slave read data
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.hdc_ad_out <= '0;
            bus.hdc_ad_oe_n <= 1'b1;
        end else if (state_nxt == HM_UPPER) begin
            bus.hdc_ad_out <= {{(DATA_W-ADDR_HI_W){1'b0}}, addr_r[ADDR_W-1:ADDR_LO_W]};
            bus.hdc_ad_oe_n <= 1'b0;
        end else if (state_nxt == HM_LOWER) begin
            bus.hdc_ad_out <= addr_r[ADDR_LO_W-1:0];
            bus.hdc_ad_oe_n <= 1'b0;
        end else if (state_nxt == HM_STROBE && write_r) begin
            bus.hdc_ad_out <= wdata_r;
            bus.hdc_ad_oe_n <= 1'b0;
        end else if (slave_acc && !bus.rd_n_line) begin
            bus.hdc_ad_out <= reg_rdata_i;
            bus.hdc_ad_oe_n <= 1'b0;
        end else begin
            bus.hdc_ad_oe_n <= 1'b1;
        end
    end

    // Master read data taken as ready ends the strobe
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            xfer_rdata_o <= '0;
        end else if (state_r == HM_STROBE && bus.ready_line && !write_r) begin
            xfer_rdata_o <= bus.ad_line;
        end
    end

    assign slave_acc = (state_r == HM_IDLE) && !bus.chip_select_n
                       && (!bus.rd_n_line || !bus.wr_n_line);
    assign slave_start = slave_acc && !slave_acc_d_r;

    cycle_hold_timer #(.CNT_W(CNT_W)) u_wait (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(slave_start),
        .cycles_i(CNT_W'(SLAVE_WAIT)),
        .busy_o(wait_busy)
    );

    // Slave access detection and register strobes
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            slave_acc_d_r <= 1'b0;
            reg_rd_o <= 1'b0;
            reg_wr_o <= 1'b0;
            reg_sel_o <= '0;
            reg_wdata_o <= '0;
        end else begin
            slave_acc_d_r <= slave_acc;
            reg_rd_o <= slave_start && !bus.rd_n_line;
            reg_wr_o <= slave_start && !bus.wr_n_line;
            if (slave_start) begin
                reg_sel_o <= bus.reg_sel;
                reg_wdata_o <= bus.ad_line;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.hdc_ready_out <= 1'b1;
            bus.hdc_ready_oe_n <= 1'b1;
        end else begin
            bus.hdc_ready_out <= !(slave_start || wait_busy);
            bus.hdc_ready_oe_n <= !slave_acc;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            bus.hdc_irq <= 1'b1;
        end else if (irq_set_i) begin
            bus.hdc_irq <= 1'b1; // Set beats a clear in the same cycle
        end else if (irq_clr_i) begin
            bus.hdc_irq <= 1'b0;
        end
    end
endmodule // hdc_bus_end

// >>> shared/cpu_bus_exchange_if.sv
`timescale 1ns/1ns
interface cpu_bus_exchange_if;
    import cpu_bus_exchange_pkg::*;
    // Controller-driven
    logic hdc_bus_request;
    logic hdc_ale;
    logic hdc_upper_strobe;
    logic hdc_rd_n_out, hdc_rd_oe_n;
    logic hdc_wr_n_out, hdc_wr_oe_n;
    logic hdc_ready_out, hdc_ready_oe_n;
    logic [DATA_W-1:0] hdc_ad_out;
    logic hdc_ad_oe_n;
    logic hdc_irq;
    // Adapter-driven
    logic hdc_bus_granted_n;
    logic adp_rd_n_out, adp_rd_oe_n;
    logic adp_wr_n_out, adp_wr_oe_n;
    logic adp_ready_out, adp_ready_oe_n;
    logic [DATA_W-1:0] adp_ad_out;
    logic adp_ad_oe_n;
    logic [SEL_W-1:0] reg_sel;
    logic addr0;
    logic chip_select_n;
    logic high_byte_enable_n;
    // Resolved shared lines
    logic rd_n_line, wr_n_line, ready_line;
    logic [DATA_W-1:0] ad_line;

    assign rd_n_line = line_level(hdc_rd_oe_n, hdc_rd_n_out, adp_rd_oe_n, adp_rd_n_out);
    assign wr_n_line = line_level(hdc_wr_oe_n, hdc_wr_n_out, adp_wr_oe_n, adp_wr_n_out);
    assign ready_line = line_level(hdc_ready_oe_n, hdc_ready_out,
                                   adp_ready_oe_n, adp_ready_out);
    assign ad_line = !hdc_ad_oe_n ? hdc_ad_out : (!adp_ad_oe_n ? adp_ad_out : '0);

    modport hdc (
        output hdc_bus_request, hdc_ale, hdc_upper_strobe, hdc_rd_n_out, hdc_rd_oe_n,
        output hdc_wr_n_out, hdc_wr_oe_n, hdc_ready_out, hdc_ready_oe_n,
        output hdc_ad_out, hdc_ad_oe_n, hdc_irq,
        input hdc_bus_granted_n, reg_sel, addr0, chip_select_n, high_byte_enable_n,
        input rd_n_line, wr_n_line, ready_line, ad_line
    );
    modport adapter (
        input hdc_bus_request, hdc_ale, hdc_upper_strobe, hdc_irq,
        output hdc_bus_granted_n, adp_rd_n_out, adp_rd_oe_n, adp_wr_n_out, adp_wr_oe_n,
        output adp_ready_out, adp_ready_oe_n, adp_ad_out, adp_ad_oe_n,
        output reg_sel, addr0, chip_select_n, high_byte_enable_n,
        input rd_n_line, wr_n_line, ready_line, ad_line
    );
endinterface

// >>> shared/cpu_bus_exchange_pkg.sv
package cpu_bus_exchange_pkg;
    // Clock and bus-request hold timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int BR_HOLD_NS = 20;
    localparam int BR_HOLD_RAW = (BR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BR_HOLD_CYC = (BR_HOLD_RAW < 1) ? 1 : BR_HOLD_RAW;
    // Controller slave access stretch, in cycles
    localparam int SLAVE_WAIT_CYC = 2;
    localparam int CNT_W = 4;
    // Bus widths
    localparam int ADDR_LO_W = 16;
    localparam int ADDR_HI_W = 8;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int SEL_W = 3;
    localparam int BASE_W = 20;
    // Chip select window, cpu address bits 23..4
    localparam logic [BASE_W-1:0] HDC_BASE_DEFAULT = 20'h00fe0;
    // Level of an undriven pulled-up line
    localparam logic LINE_IDLE = 1'b1;

    typedef enum logic [1:0] {
        ARB_IDLE = 2'b00,
        ARB_REQ = 2'b01,
        ARB_WAIT_AS = 2'b11,
        ARB_OWN = 2'b10
    } arb_state_t;

    typedef enum logic [2:0] {
        HM_IDLE = 3'b000,
        HM_REQ = 3'b001,
        HM_UPPER = 3'b011,
        HM_LOWER = 3'b010,
        HM_STROBE = 3'b110,
        HM_RELEASE = 3'b111
    } hdc_master_t;

    // Resolve a line driven by up to two parties, pulled up when idle
    function automatic logic line_level(input logic a_oe_n, input logic a,
                                        input logic b_oe_n, input logic b);
        line_level = !a_oe_n ? a : (!b_oe_n ? b : LINE_IDLE);
    endfunction
endpackage

// >>> test/cpu_bus_exchange_adapter_bench.sv
`timescale 1ns/1ns
module cpu_bus_exchange_adapter_bench;
    import cpu_bus_exchange_pkg::*;
    logic core_clk_i, rst_n_i, address_strobe_n_i, read_not_write_i, lower_byte_strobe_n_i;
    logic upper_byte_strobe_n_i, cpu_grant_n_i, mem_ready_i, xfer_req_i, xfer_write_i;
    logic irq_set_i, irq_clr_i, cpu_ready_n_o, cpu_bus_request_n_o, grant_acknowledge_n_o;
    logic mem_as_n_o, mem_rnw_o, mem_data_strobe_n_o, mem_ctl_oe_n_o, mem_data_oe_n_o, irq_o;
    logic xfer_busy_o, xfer_done_o, reg_rd_o, reg_wr_o;
    logic [ADDR_W-1:1] cpu_addr_i;
    logic [DATA_W-1:0] cpu_data_i, cpu_data_o, mem_data_o, mem_data_i, xfer_wdata_i;
    logic [DATA_W-1:0] xfer_rdata_o, reg_wdata_o, reg_rdata_i;
    logic [ADDR_W-1:0] mem_addr_o, xfer_addr_i;
    logic [SEL_W-1:0] reg_sel_o;
    logic [DATA_W-1:0] exp_q[$];
    int bad_count = 0;
    int checked = 0;
    cpu_bus_exchange_if bus ();
    hdc_bus_end i_hdc_bus_end (.*);
    cpu_bus_exchange_adapter i_cpu_bus_exchange_adapter (.*);
    cpu_bus_exchange_properties i_cpu_bus_exchange_properties (.core_clk_i, .rst_n_i,
        .cpu_bus_request_n_o, .grant_acknowledge_n_o, .cpu_grant_n_i, .address_strobe_n_i,
        .mem_ctl_oe_n_o, .hdc_bus_request(bus.hdc_bus_request), .addr0(bus.addr0),
        .hdc_bus_granted_n(bus.hdc_bus_granted_n), .high_byte_enable_n(bus.high_byte_enable_n),
        .hdc_rd_oe_n(bus.hdc_rd_oe_n), .adp_rd_oe_n(bus.adp_rd_oe_n));
    // Clock, 100 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // Drive just after the edge so nothing races the design
    task automatic step();
        @(posedge core_clk_i);
        #10;
    endtask
    task automatic check(input logic [ADDR_W-1:0] seen, input logic [ADDR_W-1:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("counts: %0d checked, %0d mismatches", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // A wait that ran out ends the run rather than hang
    task automatic bound(input int n);
        if (n >= 60) begin
            check(ADDR_W'(n), 24'h0);
            print_verdict();
        end
    endtask
    // Master word transfer; cpu is mid-cycle when it grants, memory stalls
    task automatic mxfer(input logic w);
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d, seen;
        int n;
        a = ADDR_W'($urandom);
        d = DATA_W'($urandom);
        exp_q.push_back(d);
        {xfer_write_i, xfer_addr_i, xfer_wdata_i, mem_data_i} = {w, a, d, d};
        {xfer_req_i, address_strobe_n_i} = 2'h2;
        step();
        xfer_req_i = 1'b0;
        for (n = 0; n < 60 && cpu_bus_request_n_o; n++) step();
        bound(n);
        cpu_grant_n_i = 1'b0;
        repeat (3) step();
        check(grant_acknowledge_n_o, 24'h1);
        address_strobe_n_i = 1'b1;
        for (n = 0; n < 60 && !xfer_done_o; n++) begin
            mem_ready_i = n > 8;
            if (!mem_data_oe_n_o) seen = mem_data_o;
            if (!mem_as_n_o) check(mem_addr_o, a);
            step();
        end
        bound(n);
        cpu_grant_n_i = 1'b1;
        check(w ? seen : xfer_rdata_o, exp_q.pop_front());
        check(mem_addr_o, a);
        $display("test master %0d done", w);
    endtask
    // Slave word access, decoded or outside the window
    task automatic sacc(input logic w, input logic hit);
        logic [SEL_W-1:0] s;
        logic [DATA_W-1:0] d;
        int n;
        s = SEL_W'($urandom);
        d = DATA_W'($urandom);
        cpu_addr_i = {HDC_BASE_DEFAULT + BASE_W'(!hit), s};
        {cpu_data_i, reg_rdata_i, read_not_write_i} = {d, d, !w};
        {address_strobe_n_i, lower_byte_strobe_n_i, upper_byte_strobe_n_i} = 3'h0;
        for (n = 0; n < 60 && cpu_ready_n_o; n++) step();
        if (hit) begin
            bound(n);
            check(w ? reg_wdata_o : cpu_data_o, d);
            check(reg_sel_o, s);
            check(ADDR_W'(n > SLAVE_WAIT_CYC), 24'h1);
        end else begin
            check(ADDR_W'(n), 24'h3c);
        end
        {address_strobe_n_i, lower_byte_strobe_n_i, upper_byte_strobe_n_i} = 3'h7;
        repeat (3) step();
        $display("test slave %0d %0d done", w, hit);
    endtask
    // Main sequence
    initial begin
        {rst_n_i, xfer_req_i, xfer_write_i, irq_set_i, irq_clr_i} = 5'h0;
        {address_strobe_n_i, read_not_write_i, lower_byte_strobe_n_i} = 3'h7;
        {upper_byte_strobe_n_i, cpu_grant_n_i, mem_ready_i} = 3'h7;
        {cpu_addr_i, cpu_data_i, mem_data_i, xfer_addr_i, xfer_wdata_i, reg_rdata_i} = '0;
        void'($urandom(36024));
        repeat (20) step();
        rst_n_i = 1'b1;
        repeat (2) step();
        check(irq_o, 24'h1);
        check(cpu_bus_request_n_o, 24'h1);
        irq_clr_i = 1'b1;
        step();
        irq_clr_i = 1'b0;
        step();
        check(irq_o, 24'h0);
        for (int i = 0; i < 4; i++) begin
            mxfer(i[0]);
            sacc(i[1], 1'b1);
        end
        sacc(1'b0, 1'b0);
        print_verdict();
    end
endmodule // cpu_bus_exchange_adapter_bench

// >>> test/cpu_bus_exchange_properties.sv
`timescale 1ns/1ns
module cpu_bus_exchange_properties (
    input wire logic core_clk_i, // Clock
    input wire logic rst_n_i, // Reset
    input wire logic hdc_bus_request, // Controller request
    input wire logic hdc_bus_granted_n, // Controller owns bus
    input wire logic cpu_bus_request_n_o, // Request to cpu
    input wire logic grant_acknowledge_n_o, // Acknowledge
    input wire logic cpu_grant_n_i, // Cpu grant
    input wire logic address_strobe_n_i, // Cpu strobe
    input wire logic high_byte_enable_n, // Word select
    input wire logic addr0, // Low address bit
    input wire logic hdc_rd_oe_n, // Controller drives read
    input wire logic adp_rd_oe_n, // Adapter drives read
    input wire logic mem_ctl_oe_n_o // Master strobe enable
);
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Arbitration handshake, cycle figures and cycle windows from the hand-over
    chk_req_prompt: assert property (
        $rose(hdc_bus_request) && grant_acknowledge_n_o |=> !cpu_bus_request_n_o)
        else $error("cpu request late");
    chk_ack_after_as: assert property (
        $fell(grant_acknowledge_n_o) |-> $past(address_strobe_n_i) && !$past(cpu_grant_n_i, 2))
        else $error("acknowledge before strobe end");
    chk_granted_inverse: assert property (
        hdc_bus_granted_n == grant_acknowledge_n_o) else $error("granted not inverse");
    chk_req_hold: assert property (
        $fell(grant_acknowledge_n_o) |-> !cpu_bus_request_n_o ##[1:3] cpu_bus_request_n_o)
        else $error("request hold wrong");
    chk_ack_release: assert property (
        $fell(hdc_bus_request) && !grant_acknowledge_n_o |-> ##[1:2] grant_acknowledge_n_o)
        else $error("acknowledge not dropped");
    chk_ack_stays: assert property (
        !grant_acknowledge_n_o && hdc_bus_request |=> !grant_acknowledge_n_o)
        else $error("acknowledge lost early");
    // Static word access pins; a slip here breaks every register access
    chk_word_only: assert property (
        !high_byte_enable_n && !addr0) else $error("word pins wrong");
    chk_no_fight: assert property (
        hdc_rd_oe_n || adp_rd_oe_n) else $error("read strobe driven twice");
    chk_master_oe: assert property (
        !mem_ctl_oe_n_o |-> !grant_acknowledge_n_o || !$past(grant_acknowledge_n_o))
        else $error("master drivers without acknowledge");
    // Main scenarios reached
    cover property ($fell(grant_acknowledge_n_o));
    cover property (!adp_rd_oe_n);
    cover property (!mem_ctl_oe_n_o);
endmodule // cpu_bus_exchange_properties
